// [common/adcc_defines.vh]
// Purpose: constants for the converter control block
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes: none
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH
`define ADCC_OFF_CTRL 12'h000
`define ADCC_OFF_STAT 12'h004
`define ADCC_OFF_RESULT 12'h008
`define ADCC_OFF_PINCFG 12'h00C
`define ADCC_OFF_PORT 12'h010
`define ADCC_OFF_BUFWR 12'h014
`define ADCC_B_ON 0
`define ADCC_B_SAMPLE 1
`define ADCC_B_AUTO 2
`define ADCC_B_RCSEL 3
`define ADCC_B_SIDL 4
`define ADCC_B_GO 5
`define ADCC_B_IE 6
`define ADCC_B_FORM_LO 8
`define ADCC_B_FORM_HI 9
`define ADCC_B_SLOT_LO 12
`define ADCC_B_SLOT_HI 15
`define ADCC_FORM_INT 2'h0
`define ADCC_FORM_SINT 2'h1
`define ADCC_FORM_FRAC 2'h2
`define ADCC_FORM_SFRAC 2'h3
`define ADCC_TAD_DIV 8'h10
`define ADCC_SAMPLE_CONTROL_BIT_TADS 8'h02
`define ADCC_CONV_TADS 8'h0C
`define ADCC_ICYC_CYCLES 8'h04
`endif

// [logic/adcc_buffer_ram.v]
// Purpose: 16 x 10-bit result buffer with registered read
// Assumes: no reset, contents unknown after power-on
// Notes: reset never touches the storage
`timescale 1ns/100ps
`default_nettype none
module adcc_buffer_ram (
    input wire clk_sys,
    input wire wrEn,
    input wire [3:0] wrAddr,
    input wire [9:0] wrData,
    input wire [3:0] rdAddr,
    output reg [9:0] rdData
);
    reg [9:0] mem [0:15];
    always @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule
`default_nettype wire

// [logic/adcc_control.v]
// Purpose: sampling, power, sleep/idle and result format control
// Assumes: AHB-Lite slave, one wait state on result reads, zero on all other transfers
// Notes: analog core is external; this block times and stores
//
// Notes on behaviour
// - sampling ends manually or automatically
// - on bit powers module, off disables it
// - sleep stops and holds module clocks low
// - sleep aborts conversion, never resumed
// - sleep leaves register contents unchanged
// - sleep operation only with RC clock
// - RC clock waits one instruction cycle first
// - completion sets done and writes buffer
// - sleep completion with interrupt wakes device
// - sleep completion without interrupt powers off
// - stop-in-idle bit halts module in idle
// - reset clears registers, aborts, turns off
// - reset keeps buffer; power-on contents unknown
// - 10-bit results read in three layouts; signed fractional reads as fractional
// - integer, signed, fractional layouts to 16 bits
// - buffer writes are always right-justified integer
// - analog pins read zero; digital pins unconverted
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.vh"
module adcc_control (
    input wire clk_sys,
    input wire srst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire sleepReq,
    input wire idleReq,
    input wire rcClk,
    input wire [9:0] convData,
    input wire [15:0] pinLevel,
    output reg wakeReq,
    output reg analogPowerOn,
    output reg moduleClk,
    output reg sampleHold,
    output reg [3:0] muxSel,
    output reg convActive
);
    localparam ST_IDLE = 5'b00001;
    localparam ST_DELAY = 5'b00010;
    localparam ST_SAMPLE_CONTROL_BIT = 5'b00100;
    localparam ST_CONV = 5'b01000;
    localparam ST_DONE = 5'b10000;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    reg sleepM_q, sleepS_q, idleM_q, idleS_q, rcM_q, rcS_q, rcP_q;
    reg [15:0] pinM_q, pinS_q;
    reg [9:0] dataM_q, dataS_q;
    always @(posedge clk_sys) begin
        sleepM_q <= sleepReq;
        sleepS_q <= sleepM_q;
        idleM_q <= idleReq;
        idleS_q <= idleM_q;
        rcM_q <= rcClk;
        rcS_q <= rcM_q;
        rcP_q <= rcS_q;
        pinM_q <= pinLevel;
        pinS_q <= pinM_q;
        dataM_q <= convData;
        dataS_q <= dataM_q;
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    reg onBit_q, sampBit_q, autoBit_q, rcSel_q, sidl_q, ie_q, done_q;
    reg [1:0] form_q;
    reg [3:0] slot_q, rdSlot_q;
    reg [15:0] pinCfg_q;
    reg sleepOff_q;
    reg [4:0] state_q;
    reg [7:0] div_q, tad_q;
    reg [3:0] wrPtr_q;
    reg aWr_q, aRd_q;
    reg [11:0] aOff_q;
    reg bufWr_q;
    reg [9:0] bufWd_q;
    wire [9:0] bufRd;
    reg bufRdOk_q;

    wire addrPh = hsel & hready & htrans[1];
    wire stopIdle = idleS_q & sidl_q;
    wire clkRun = ~sleepS_q | rcSel_q;
    wire powered = onBit_q & ~sleepOff_q & ~stopIdle;
    wire rcEdge = rcS_q & ~rcP_q;
    wire tadTick = (div_q == `ADCC_TAD_DIV - 8'h01) & powered & clkRun &
        (~rcSel_q | rcEdge);
    wire goWr = aWr_q & (aOff_q == `ADCC_OFF_CTRL) & hwdata[`ADCC_B_GO];
    wire convEnd = (state_q == ST_CONV) & tadTick &
        (tad_q == `ADCC_CONV_TADS - 8'h01);
    wire abort = ~powered | (sleepS_q & ~rcSel_q);

    ////////////////////////////////////////////////////////////////////
    // bus slave
    assign hresp = 1'b0;
    wire rdPend = aRd_q & (aOff_q == `ADCC_OFF_RESULT);
    assign hreadyout = ~rdPend | bufRdOk_q;
    always @(posedge clk_sys) begin
        if (srst) begin
            aWr_q <= 1'b0;
            aRd_q <= 1'b0;
            aOff_q <= 12'h000;
            bufRdOk_q <= 1'b0;
        end else begin
            if (hreadyout) begin
                aWr_q <= addrPh & hwrite;
                aRd_q <= addrPh & ~hwrite;
                aOff_q <= {haddr[11:2], 2'b00};
            end
            bufRdOk_q <= rdPend & ~bufRdOk_q;
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            rdSlot_q <= 4'h0;
        end else if (addrPh & ~hwrite) begin
            rdSlot_q <= slot_q;
        end
    end

    reg [15:0] fmt;
    always @* begin
        case (form_q)
            `ADCC_FORM_INT: fmt = {6'h00, bufRd};
            `ADCC_FORM_SINT: fmt = {{6{bufRd[9]}}, bufRd};
            default: fmt = {bufRd, 6'h00};
        endcase
    end

    wire [15:0] portRd = pinS_q & ~pinCfg_q;
    always @* begin
        hrdata = 32'h0000_0000;
        case (aOff_q)
            `ADCC_OFF_CTRL: hrdata = {16'h0000, slot_q, 2'b00, form_q, 1'b0,
                ie_q, 1'b0, sidl_q, rcSel_q, autoBit_q, sampBit_q, onBit_q};
            `ADCC_OFF_STAT: hrdata = {24'h000000, wrPtr_q, 1'b0,
                convActive, sampleHold, done_q};
            `ADCC_OFF_RESULT: hrdata = {16'h0000, fmt};
            `ADCC_OFF_PINCFG: hrdata = {16'h0000, pinCfg_q};
            `ADCC_OFF_PORT: hrdata = {16'h0000, portRd};
            default: hrdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // control register writes; sleep never touches them
    always @(posedge clk_sys) begin
        if (srst) begin
            onBit_q <= 1'b0;
            sampBit_q <= 1'b0;
            autoBit_q <= 1'b0;
            rcSel_q <= 1'b0;
            sidl_q <= 1'b0;
            ie_q <= 1'b0;
            form_q <= `ADCC_FORM_INT;
            slot_q <= 4'h0;
            pinCfg_q <= 16'h0000;
        end else begin
            if (aWr_q & (aOff_q == `ADCC_OFF_CTRL)) begin
                onBit_q <= hwdata[`ADCC_B_ON];
                sampBit_q <= hwdata[`ADCC_B_SAMPLE];
                autoBit_q <= hwdata[`ADCC_B_AUTO];
                rcSel_q <= hwdata[`ADCC_B_RCSEL];
                sidl_q <= hwdata[`ADCC_B_SIDL];
                ie_q <= hwdata[`ADCC_B_IE];
                form_q <= hwdata[`ADCC_B_FORM_HI:`ADCC_B_FORM_LO];
                slot_q <= hwdata[`ADCC_B_SLOT_HI:`ADCC_B_SLOT_LO];
            end else if (convEnd & ~autoBit_q) begin
                sampBit_q <= 1'b0;
            end
            if (aWr_q & (aOff_q == `ADCC_OFF_PINCFG)) begin
                pinCfg_q <= hwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
            div_q <= 8'h00;
            tad_q <= 8'h00;
            done_q <= 1'b0;
            wrPtr_q <= 4'h0;
            sleepOff_q <= 1'b0;
            wakeReq <= 1'b0;
        end else begin
            wakeReq <= 1'b0;
            if (rcSel_q ? rcEdge : 1'b1) begin
                div_q <= (tadTick | ~powered) ? 8'h00 : div_q + 8'h01;
            end
            if (~onBit_q | ~sleepS_q) begin
                sleepOff_q <= 1'b0;
            end
            if (aWr_q & (aOff_q == `ADCC_OFF_STAT) & hwdata[0]) begin
                done_q <= 1'b0;
            end
            if (aWr_q & (aOff_q == `ADCC_OFF_CTRL) & hwdata[`ADCC_B_GO]) begin
                done_q <= 1'b0;
            end
            if (abort) begin
                state_q <= ST_IDLE;
                tad_q <= 8'h00;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        // manual or automatic start of sampling
                        if (sampBit_q | autoBit_q | goWr) begin
                            state_q <= rcSel_q ? ST_DELAY : ST_SAMPLE_CONTROL_BIT;
                            tad_q <= 8'h00;
                        end
                    end
                    ST_DELAY: begin
                        if (tad_q == `ADCC_ICYC_CYCLES - 8'h01) begin
                            state_q <= ST_SAMPLE_CONTROL_BIT;
                            tad_q <= 8'h00;
                        end else begin
                            tad_q <= tad_q + 8'h01;
                        end
                    end
                    ST_SAMPLE_CONTROL_BIT: begin
                        if (tadTick & (tad_q != 8'hFF)) begin
                            tad_q <= tad_q + 8'h01;
                        end
                        // manual end on clear, auto end on count
                        if (autoBit_q ? (tadTick &
                            (tad_q == `ADCC_SAMPLE_CONTROL_BIT_TADS - 8'h01)) :
                            (~sampBit_q & (tad_q != 8'h00))) begin
                            state_q <= ST_CONV;
                            tad_q <= 8'h00;
                        end
                    end
                    ST_CONV: begin
                        if (convEnd) begin
                            state_q <= ST_DONE;
                        end else if (tadTick) begin
                            tad_q <= tad_q + 8'h01;
                        end
                    end
                    ST_DONE: begin
                        done_q <= 1'b1;
                        wrPtr_q <= wrPtr_q + 4'h1;
                        state_q <= ST_IDLE;
                        if (sleepS_q & ie_q) begin
                            wakeReq <= 1'b1;
                        end
                        if (sleepS_q & ~ie_q) begin
                            sleepOff_q <= 1'b1;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffer write path, always right-justified integer
    always @(posedge clk_sys) begin
        if (srst) begin
            bufWr_q <= 1'b0;
            bufWd_q <= 10'h000;
        end else begin
            bufWr_q <= 1'b0;
            if (state_q == ST_DONE) begin
                bufWr_q <= 1'b1;
                bufWd_q <= dataS_q;
            end else if (aWr_q & (aOff_q == `ADCC_OFF_BUFWR)) begin
                bufWr_q <= 1'b1;
                bufWd_q <= hwdata[9:0];
            end
        end
    end
    reg [3:0] bufWa_q;
    always @(posedge clk_sys) begin
        if (srst) begin
            bufWa_q <= 4'h0;
        end else if (state_q == ST_DONE) begin
            bufWa_q <= wrPtr_q;
        end else if (aWr_q & (aOff_q == `ADCC_OFF_BUFWR)) begin
            bufWa_q <= slot_q;
        end
    end

    adcc_buffer_ram uRam (
        .clk_sys(clk_sys),
        .wrEn(bufWr_q),
        .wrAddr(bufWa_q),
        .wrData(bufWd_q),
        .rdAddr(rdSlot_q),
        .rdData(bufRd)
    );

    ////////////////////////////////////////////////////////////////////
    // analog-side outputs
    always @(posedge clk_sys) begin
        if (srst) begin
            analogPowerOn <= 1'b0;
            moduleClk <= 1'b0;
            sampleHold <= 1'b0;
            convActive <= 1'b0;
            muxSel <= 4'h0;
        end else begin
            analogPowerOn <= powered;
            moduleClk <= powered & clkRun & div_q[3];
            sampleHold <= (state_q == ST_SAMPLE_CONTROL_BIT) & ~abort;
            convActive <= (state_q == ST_CONV) & ~abort;
            muxSel <= slot_q;
        end
    end
endmodule
`default_nettype wire

// [test/adcc_control_checker.sv]
// Purpose: port checks for the converter control block
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto adcc_control
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.vh"
module adcc_control_checker (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic analogPowerOn,
    input wire logic moduleClk,
    input wire logic sampleHold,
    input wire logic [3:0] muxSel,
    input wire logic convActive
);
    default clocking cb @(posedge clk_sys); endclocking
    wire take = hsel & hready & htrans[1];
    wire rdRes = take & !hwrite & (haddr[11:0] == `ADCC_OFF_RESULT);
    ////////////////////////////////////////////////////////////////////
    a_reset_idle: assert property (srst |=> !analogPowerOn
        && !convActive && !sampleHold) else $error("busy after reset");
    a_reset_quiet: assert property (srst |=> !moduleClk
        && muxSel == 4'h0) else $error("outputs live after reset");
    a_reset_ready: assert property (srst |=> hreadyout)
        else $error("bus stalled after reset");
    a_off_disables: assert property (disable iff (srst)
        !analogPowerOn |-> !convActive && !sampleHold)
        else $error("activity while powered off");
    a_off_no_clock: assert property (disable iff (srst)
        !analogPowerOn |-> !moduleClk) else $error("clock while off");
    a_result_wait: assert property (disable iff (srst)
        rdRes |=> !hreadyout ##1 hreadyout)
        else $error("result read wait state wrong");
    a_plain_nowait: assert property (disable iff (srst)
        take && !rdRes |=> hreadyout) else $error("unexpected wait");
    a_okay_resp: assert property (hresp == 1'b0)
        else $error("error response");
    cover property (rdRes);
    cover property ($fell(convActive));
    cover property ($rose(sampleHold));
endmodule
bind adcc_control adcc_control_checker chk (.clk_sys(clk_sys),
    .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .analogPowerOn(analogPowerOn),
    .moduleClk(moduleClk), .sampleHold(sampleHold), .muxSel(muxSel),
    .convActive(convActive));
`default_nettype wire

// [test/adcc_control_tb.sv]
// Purpose: register-level tests of the converter control block
// Assumes: AHB-Lite single word transfers, rcClk rises every 4 clocks
// Notes: conversion timing from TAD of 16 clocks
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.vh"
module adcc_control_tb;
    logic clk_sys, srst, hsel, hwrite, sleepReq, idleReq, rcClk;
    logic [1:0] htrans, f;
    logic [31:0] haddr, hwdata, rd;
    logic [9:0] convData, v;
    logic [15:0] pinLevel;
    wire [31:0] hrdata;
    wire hreadyout, hresp, wakeReq, analogPowerOn;
    wire moduleClk, sampleHold, convActive;
    wire [3:0] muxSel;
    int mismatches, checked, cycles, n;
    adcc_control uut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sleepReq(sleepReq),
        .idleReq(idleReq), .rcClk(rcClk), .convData(convData),
        .pinLevel(pinLevel), .wakeReq(wakeReq),
        .analogPowerOn(analogPowerOn), .moduleClk(moduleClk),
        .sampleHold(sampleHold), .muxSel(muxSel),
        .convActive(convActive));
    ////////////////////////////////////////////////////////////////////
    task automatic ahb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h00000, a};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic summarize;
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic convert;
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000003);
        repeat (40) @(posedge clk_sys);
        cmp({31'h0, sampleHold}, 32'h1);
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000001);
    endtask
    task automatic waitDone;
        n = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 200) begin
            ahb(1'b0, `ADCC_OFF_STAT, 32'h0);
            n++;
        end
    endtask
    function automatic logic [31:0] fmt(input logic [1:0] m,
        input logic [9:0] x);
        if (m == `ADCC_FORM_INT) return {22'h000000, x};
        if (m == `ADCC_FORM_SINT) return {16'h0000, {6{x[9]}}, x};
        return {16'h0000, x, 6'h00};
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        rcClk <= cycles[1];
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        sleepReq = 1'b0;
        idleReq = 1'b0;
        convData = 10'h000;
        pinLevel = 16'hA5C3;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        ahb(1'b0, `ADCC_OFF_CTRL, 32'h0);
        cmp(rd, 32'h00000000);
        ahb(1'b0, 12'h020, 32'h0);
        cmp(rd, 32'h00000000);
        ahb(1'b1, `ADCC_OFF_PINCFG, 32'h000000F0);
        ahb(1'b0, `ADCC_OFF_PORT, 32'h0);
        cmp(rd, 32'h0000A503);
        for (int k = 0; k < 8; k++) begin
            v = k[0] ? 10'h15A : 10'h2A5;
            f = k[2:1];
            ahb(1'b1, `ADCC_OFF_CTRL, {22'h000000, f, 8'h00});
            ahb(1'b1, `ADCC_OFF_BUFWR, {22'h000000, v});
            ahb(1'b0, `ADCC_OFF_RESULT, 32'h0);
            cmp(rd, fmt(f, v));
        end
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h0000A000);
        repeat (2) @(posedge clk_sys);
        cmp({28'h0, muxSel}, 32'h0000000A);
        convData <= 10'h1C3;
        convert();
        cmp({31'h0, analogPowerOn}, 32'h1);
        waitDone();
        cmp({31'h0, rd[0]}, 32'h1);
        ahb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        cmp(rd, 32'h000001C3);
        ahb(1'b1, `ADCC_OFF_STAT, 32'h00000001);
        convData <= 10'h0F0;
        convert();
        repeat (20) @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        cmp({31'h0, convActive}, 32'h0);
        srst <= 1'b0;
        ahb(1'b0, `ADCC_OFF_CTRL, 32'h0);
        cmp(rd, 32'h00000000);
        ahb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        cmp(rd, 32'h000001C3);
        convert();
        repeat (20) @(posedge clk_sys);
        sleepReq <= 1'b1;
        repeat (10) @(posedge clk_sys);
        cmp({31'h0, convActive}, 32'h0);
        cmp({31'h0, moduleClk}, 32'h0);
        sleepReq <= 1'b0;
        repeat (300) @(posedge clk_sys);
        ahb(1'b0, `ADCC_OFF_STAT, 32'h0);
        cmp({31'h0, rd[0]}, 32'h0);
        ahb(1'b0, `ADCC_OFF_CTRL, 32'h0);
        cmp(rd, 32'h00000001);
        convData <= 10'h2AA;
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000005);
        waitDone();
        cmp({31'h0, rd[0]}, 32'h1);
        ahb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        cmp(rd, 32'h000002AA);
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000000);
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000049);
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000069);
        sleepReq <= 1'b1;
        n = 0;
        while (wakeReq !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        cmp({31'h0, wakeReq}, 32'h1);
        sleepReq <= 1'b0;
        ahb(1'b0, `ADCC_OFF_STAT, 32'h0);
        cmp({31'h0, rd[0]}, 32'h1);
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000029);
        sleepReq <= 1'b1;
        n = 0;
        while (analogPowerOn !== 1'b0 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        ahb(1'b0, `ADCC_OFF_CTRL, 32'h0);
        cmp(rd, 32'h00000009);
        cmp({31'h0, analogPowerOn}, 32'h0);
        sleepReq <= 1'b0;
        repeat (8) @(posedge clk_sys);
        cmp({31'h0, analogPowerOn}, 32'h1);
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000011);
        idleReq <= 1'b1;
        repeat (6) @(posedge clk_sys);
        cmp({31'h0, analogPowerOn}, 32'h0);
        ahb(1'b1, `ADCC_OFF_CTRL, 32'h00000001);
        repeat (6) @(posedge clk_sys);
        cmp({31'h0, analogPowerOn}, 32'h1);
        idleReq <= 1'b0;
        summarize();
    end
endmodule
`default_nettype wire
